/* actuator_diag_chk.sv */
// assertion checker for the diagnostic and calibration control
`timescale 1ns/100ps
`include "actuator_diag_defs.svh"
module actuator_diag_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        over_temp,
    input wire logic        undervoltage_lockout,
    input wire logic        drive_active
);
    logic [1:0] mode_r;
    logic [7:0] run_r;
    wire        acc   = psel && penable;
    wire        hit   = paddr inside {`ADDR_MODE_CTRL, `ADDR_GO, `ADDR_CAL_IN, `ADDR_CAL_OUT, `ADDR_STATUS};
    wire        go_wr = acc && pwrite && paddr == `ADDR_GO && pwdata[0];
    wire        diag  = mode_r == `MODE_DIAG;
    // shadow of the mode field and length of the current run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= 2'h0;
            run_r  <= 8'h00;
        end else begin
            if (acc && pwrite && paddr == `ADDR_MODE_CTRL)
                mode_r <= pwdata[1:0];
            run_r <= !drive_active ? 8'h00 : (run_r == 8'hFF ? run_r : run_r + 8'h01);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_high_a:
    assert property (pready) else $error("pready low");
    slverr_map_a:
    assert property (acc && !hit |-> pslverr) else $error("no error on unmapped access");
    slverr_quiet_a:
    assert property (!acc || hit |-> !pslverr) else $error("stray error response");
    rdata_unmapped_a:
    assert property (psel && !pwrite && !hit |-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
    go_launch_a:
    assert property (go_wr && mode_r[1] && !drive_active |-> ##[1:2] drive_active) else $error("start ignored");
    idle_mode_a:
    assert property (!mode_r[1] && !drive_active |=> !drive_active) else $error("run outside routine modes");
    diag_length_a:
    assert property (diag |-> run_r <= 8'd84) else $error("diagnostic run too long");
    diag_abort_a:
    assert property (diag && drive_active && (over_temp || undervoltage_lockout) |-> ##[1:3] !drive_active)
        else $error("no abort on critical condition");
    cover property (go_wr && mode_r == `MODE_AUTOCAL);
    cover property (diag && $fell(drive_active));
    cover property (acc && !hit);
endmodule // actuator_diag_chk
bind actuator_diag_ctrl actuator_diag_chk actuator_diag_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .over_temp, .undervoltage_lockout, .drive_active);

/* actuator_diag_ctrl.sv */
// diagnostic and auto-calibration control with apb register file
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "actuator_diag_defs.svh"

// Overview of operation
// - closed loop after calibration: device adjusts level and resonant frequency
// - mode field value two selects the actuator diagnostic routine
// - diagnostic problem sets the diagnostic fault flag
// - undervoltage, overtemperature or overcurrent aborts routine and sets fault
// - resistance measured first, stored in impedance result field
// - overtemperature or undervoltage stops at once, no result, back to standby
// - resistance step never flags overcurrent or fault (code sets fault there on undervoltage or overtemperature)
// - diagnostic waveform faults on short, open load or missing back emf
// - calibration end overwrites configuration outputs with computed values
// - resonant-only calibration inputs ignored with eccentric motor
// - duration codes 0,1,2 give 250ms, 500ms, 1s
// - code 3 runs from start trigger until stop trigger, then publishes
// - triggers from start bit, or pin when its function is trigger
// - mode value 3 selects auto calibration
// - start bit launches calibration and self-clears at completion
// - calibration results kept in standby or while enable low
module actuator_diag_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        trig_pin,
    input  wire logic        undervoltage_lockout,
    input  wire logic        over_temp,
    input  wire logic        over_current,
    input  wire logic [7:0]  measured_impedance,
    input  wire logic        load_short,
    input  wire logic        load_open,
    input  wire logic        back_emf_valid,
    input  wire logic [7:0]  cal_comp_result,
    input  wire logic [7:0]  cal_back_emf_gain_result,
    input  wire logic [7:0]  cal_period_result,
    output logic             drive_active,
    output logic             closed_loop_active,
    output logic             resonance_tracking
);
    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire wr_en   = psel & penable & pwrite;
    wire hit_mode = (paddr == `ADDR_MODE_CTRL);
    wire hit_go   = (paddr == `ADDR_GO);
    wire hit_in   = (paddr == `ADDR_CAL_IN);
    wire hit_out  = (paddr == `ADDR_CAL_OUT);
    wire hit_stat = (paddr == `ADDR_STATUS);
    wire mapped   = hit_mode | hit_go | hit_in | hit_out | hit_stat;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // mode_ctrl: [1:0] mode, [2] actuator_type_select, [3] loop control,
    // [5:4] trigger_pin_function, [15:8] open_loop_resonant_period
    logic [15:0] mode_ctrl_r;
    // cal_in: [2:0] feedback_brake_factor, [5:4] loop gain, [7:6] cal duration,
    // [9:8] sample time, [15:12] backemf_a, [19:16] current_dissipation_time,
    // [21:20] zero_cross_detect_time, [31:24] overdrive_clamp_level
    logic [31:0] cal_in_r;
    logic [31:0] cal_out_r;
    logic        go_r;
    logic        go_nxt;
    logic        diagnostic_fault_flag_r;
    logic        fault_nxt;
    logic [7:0]  impedance_result_r;
    logic        calibrated_r;
    actuator_diag_pkg::seq_state_type state_r;
    actuator_diag_pkg::seq_state_type state_nxt;

    wire [1:0] mode          = mode_ctrl_r[1:0];
    wire       actuator_type_select = mode_ctrl_r[2];
    wire       loop_open     = mode_ctrl_r[3];
    wire [1:0] trigger_pin_function = mode_ctrl_r[5:4];
    wire [1:0] cal_duration  = cal_in_r[7:6];

    // ----------------------------------------
    // triggers
    // ----------------------------------------
    logic pin_trig;
    wire  go_write1 = wr_en & hit_go & pwdata[0];
    wire  go_write0 = wr_en & hit_go & ~pwdata[0];
    wire  start_trig = go_write1 | pin_trig;

    trigger_detect u_trig (
        .pclk       (pclk),
        .presetn    (presetn),
        .enable     (trigger_pin_function == `TRIG_FUNC_TRIG),
        .trig_pin   (trig_pin),
        .trig_pulse (pin_trig)
    );

    // ----------------------------------------
    // phase timer
    // ----------------------------------------
    logic        timer_load;
    logic [31:0] timer_value;
    logic        timer_done;

    cycle_timer u_timer (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (timer_load),
        .load_value (timer_value),
        .expired    (timer_done)
    );

    function automatic logic [31:0] cal_cycles(input logic [1:0] code);
        case (code)
            2'h0:    cal_cycles = 32'(`MS_TO_CYC(`CAL_T0_MS));
            2'h1:    cal_cycles = 32'(`MS_TO_CYC(`CAL_T1_MS));
            default: cal_cycles = 32'(`MS_TO_CYC(`CAL_T2_MS));
        endcase
    endfunction

    wire critical_abort = undervoltage_lockout | over_temp;
    wire timed_cal      = (cal_duration != `CAL_TIME_TRIG);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        state_nxt   = state_r;
        go_nxt      = go_r;
        fault_nxt   = diagnostic_fault_flag_r;
        timer_load  = 1'b0;
        timer_value = 32'h0000_0000;
        case (state_r)
            actuator_diag_pkg::ST_STANDBY: begin
                // modes 0 and 1 start nothing, so the start bit is left clear there
                if (start_trig && mode[1]) begin
                    go_nxt = 1'b1;
                    if (mode == `MODE_DIAG) begin
                        fault_nxt   = 1'b0;
                        state_nxt   = actuator_diag_pkg::ST_ZMEAS;
                        timer_load  = 1'b1;
                        timer_value = 32'(`ZMEAS_CYCLES);
                    end else if (mode == `MODE_AUTOCAL) begin
                        fault_nxt   = 1'b0;
                        state_nxt   = actuator_diag_pkg::ST_CAL;
                        timer_load  = timed_cal;
                        timer_value = cal_cycles(cal_duration);
                    end
                end
            end
            actuator_diag_pkg::ST_ZMEAS: begin
                // over-current is not looked at here
                if (critical_abort) begin
                    fault_nxt = 1'b1;
                    go_nxt    = 1'b0;
                    state_nxt = actuator_diag_pkg::ST_STANDBY;
                end else if (timer_done) begin
                    state_nxt   = actuator_diag_pkg::ST_FUNC;
                    timer_load  = 1'b1;
                    timer_value = 32'(`FUNC_CYCLES);
                end
            end
            actuator_diag_pkg::ST_FUNC: begin
                if (critical_abort || over_current || load_short || load_open) begin
                    fault_nxt = 1'b1;
                    go_nxt    = 1'b0;
                    state_nxt = actuator_diag_pkg::ST_STANDBY;
                end else if (timer_done) begin
                    if (!back_emf_valid) begin
                        fault_nxt = 1'b1;
                    end
                    go_nxt    = 1'b0;
                    state_nxt = actuator_diag_pkg::ST_STANDBY;
                end
            end
            actuator_diag_pkg::ST_CAL: begin
                if (critical_abort || over_current) begin
                    fault_nxt = 1'b1;
                    go_nxt    = 1'b0;
                    state_nxt = actuator_diag_pkg::ST_STANDBY;
                end else if (timed_cal ? timer_done : (go_write0 || pin_trig)) begin
                    state_nxt = actuator_diag_pkg::ST_DONE;
                end
            end
            actuator_diag_pkg::ST_DONE: begin
                go_nxt    = 1'b0;
                state_nxt = actuator_diag_pkg::ST_STANDBY;
            end
            default: begin
                state_nxt = actuator_diag_pkg::ST_STANDBY;
            end
        endcase
    end

    wire publish = (state_r == actuator_diag_pkg::ST_DONE);
    wire z_store = (state_r == actuator_diag_pkg::ST_ZMEAS) & timer_done & ~critical_abort;

    // resonant-only calibration outputs are not taken for the eccentric motor
    wire [7:0] period_out = actuator_type_select ? cal_period_result : cal_out_r[23:16];

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ctrl_r <= 16'h0000;
            cal_in_r    <= `CAL_IN_RESET;
        end else begin
            if (wr_en && hit_mode) begin
                mode_ctrl_r <= pwdata[15:0];
            end
            if (wr_en && hit_in) begin
                cal_in_r <= pwdata;
            end
        end
    end

    // results held across standby; only reset, a new calibration or a host write to cal_out_r alters them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_out_r    <= `CAL_OUT_RESET;
            calibrated_r <= 1'b0;
        end else if (publish) begin
            cal_out_r    <= {8'h00, period_out, cal_back_emf_gain_result, cal_comp_result};
            calibrated_r <= 1'b1;
        end else if (wr_en && hit_out) begin
            cal_out_r <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            impedance_result_r <= 8'h00;
        end else if (z_store) begin
            impedance_result_r <= measured_impedance;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r                 <= actuator_diag_pkg::ST_STANDBY;
            go_r                    <= 1'b0;
            diagnostic_fault_flag_r <= 1'b0;
        end else begin
            state_r                 <= state_nxt;
            go_r                    <= go_nxt;
            diagnostic_fault_flag_r <= fault_nxt;
        end
    end

    // ----------------------------------------
    // drive status
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_active       <= 1'b0;
            closed_loop_active <= 1'b0;
            resonance_tracking <= 1'b0;
        end else begin
            drive_active       <= (state_nxt != actuator_diag_pkg::ST_STANDBY);
            closed_loop_active <= ~loop_open & calibrated_r;
            resonance_tracking <= ~loop_open & calibrated_r & actuator_type_select;
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    wire [31:0] stat_word = {20'h0_0000, impedance_result_r, state_r, diagnostic_fault_flag_r};

    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            case (1'b1)
                hit_mode: prdata = {16'h0000, mode_ctrl_r};
                hit_go:   prdata = {31'h0000_0000, go_r};
                hit_in:   prdata = cal_in_r;
                hit_out:  prdata = cal_out_r;
                hit_stat: prdata = stat_word;
                default:  prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule // actuator_diag_ctrl

/* actuator_diag_defs.svh */
// register offsets, field codes, reset values and timing counts
`ifndef ACTUATOR_DIAG_DEFS_SVH
`define ACTUATOR_DIAG_DEFS_SVH

`define ADDR_MODE_CTRL      12'h000
`define ADDR_GO             12'h004
`define ADDR_CAL_IN         12'h008
`define ADDR_CAL_OUT        12'h00C
`define ADDR_STATUS         12'h010

`define MODE_DIAG           2'h2
`define MODE_AUTOCAL        2'h3
`define CAL_TIME_TRIG       2'h3
`define TRIG_FUNC_TRIG      2'h1

`define CAL_IN_RESET        32'h0000_0000
`define CAL_OUT_RESET       32'h0000_0000

`define CLK_FREQ_HZ         25000000
`define CAL_T0_MS           250
`define CAL_T1_MS           500
`define CAL_T2_MS           1000
`define MS_TO_CYC(ms)       ((ms) * (`CLK_FREQ_HZ / 1000))
`define ZMEAS_CYCLES        16
`define FUNC_CYCLES         64

`endif

/* actuator_diag_pkg.sv */
// types shared by the diagnostic and calibration control files
package actuator_diag_pkg;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b000,
        ST_ZMEAS   = 3'b001,
        ST_FUNC    = 3'b010,
        ST_CAL     = 3'b011,
        ST_DONE    = 3'b100
    } seq_state_type;

endpackage

/* cycle_timer.sv */
// down-counting timer for routine phases
`timescale 1ns/100ps
module cycle_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load,
    input  wire logic [31:0] load_value,
    output logic             expired
);
    logic [31:0] count_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 32'h0000_0000;
        end else if (load) begin
            count_r <= load_value;
        end else if (count_r != 32'h0000_0000) begin
            count_r <= count_r - 32'h0000_0001;
        end
    end

    assign expired = (count_r == 32'h0000_0001);
endmodule // cycle_timer

/* host_apb_model.sv */
// apb host model that configures and starts the control block
`timescale 1ns/100ps
module host_apb_model (
    input wire logic        pclk,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [11:0]     paddr,
    output logic [31:0]     pwdata
);
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            tb_actuator_diag_and_autocal_control.error_cnt++;
            tb_actuator_diag_and_autocal_control.end_sim();
        end
    endtask
endmodule // host_apb_model

/* tb_actuator_diag_and_autocal_control.sv */
// self-checking bench for the diagnostic and calibration control
`timescale 1ns/100ps
`include "actuator_diag_defs.svh"
module tb_actuator_diag_and_autocal_control;
    logic        pclk, presetn, trig_pin, undervoltage_lockout, over_temp, over_current, load_short, load_open;
    logic        back_emf_valid, psel, penable, pwrite, pready, pslverr, e;
    logic        drive_active, closed_loop_active, resonance_tracking;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  measured_impedance, cal_comp_result, cal_back_emf_gain_result, cal_period_result, m_imp, m_per;
    logic [15:0] seed;
    int          error_cnt, compares, k;
    actuator_diag_ctrl actuator_diag_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .trig_pin, .undervoltage_lockout, .over_temp, .over_current, .measured_impedance,
        .load_short, .load_open, .back_emf_valid, .cal_comp_result, .cal_back_emf_gain_result, .cal_period_result,
        .drive_active, .closed_loop_active, .resonance_tracking);
    host_apb_model host_apb_model_i (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic end_sim();
        if (error_cnt == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
        host_apb_model_i.xfer(1'b0, a, 32'h0000_0000, q, e);
        chk(n, x, q);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host_apb_model_i.xfer(1'b1, a, d, q, e);
    endtask
    // polls the start bit until it self-clears
    task automatic wait_go();
        int n;
        n = 0;
        do begin
            host_apb_model_i.xfer(1'b0, `ADDR_GO, 32'h0000_0000, q, e);
            n++;
        end while (q[0] !== 1'b0 && n < 100);
        chk("go clear", 32'h0000_0000, {31'h0, q[0]});
        if (q[0] !== 1'b0)
            end_sim();
    endtask
    initial begin
        presetn = 1'b0;
        {trig_pin, undervoltage_lockout, over_temp, over_current, load_short, load_open} = 6'h00;
        back_emf_valid = 1'b1;
        {measured_impedance, cal_comp_result, cal_back_emf_gain_result, cal_period_result} = 32'h0000_0000;
        {error_cnt, compares} = 0;
        seed = 16'h8F25;
        {m_imp, m_per} = 16'h0000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ADDR_STATUS, 32'h0000_0000, "status");
        rd(`ADDR_CAL_OUT, `CAL_OUT_RESET, "cal out");
        rd(`ADDR_CAL_IN, `CAL_IN_RESET, "cal in");
        rd(12'h014, 32'h0000_0000, "unmapped");
        chk("unmapped err", 32'h0000_0001, {31'h0, e});
        wr(`ADDR_MODE_CTRL, {30'h0, `MODE_DIAG});
        for (k = 0; k < 7; k++) begin
            seed = lfsr(seed);
            @(posedge pclk);
            measured_impedance   <= seed[7:0];
            load_open            <= k == 1;
            back_emf_valid       <= k != 2;
            over_temp            <= k == 3;
            over_current         <= k == 4;
            undervoltage_lockout <= k == 5;
            load_short           <= k == 6;
            wr(`ADDR_GO, 32'h0000_0001);
            wait_go();
            if (k != 3 && k != 5)
                m_imp = seed[7:0];
            rd(`ADDR_STATUS, {20'h0, m_imp, actuator_diag_pkg::ST_STANDBY, k != 0}, "diag");
        end
        @(posedge pclk);
        {over_temp, over_current, undervoltage_lockout, load_open, load_short} <= 5'h00;
        back_emf_valid <= 1'b1;
        for (k = 0; k < 2; k++) begin
            seed = lfsr(seed);
            @(posedge pclk);
            {cal_period_result, cal_back_emf_gain_result, cal_comp_result} <= {seed[7:0], seed[15:8], seed[11:4]};
            wr(`ADDR_MODE_CTRL, k == 0 ? 32'h0000_0017 : 32'h0000_0013);
            wr(`ADDR_CAL_IN, 32'h0001_13E3);
            rd(`ADDR_CAL_IN, 32'h0001_13E3, "cal in set");
            wr(`ADDR_GO, 32'h0000_0001);
            repeat (40) @(posedge pclk);
            chk("running", 32'h0000_0001, {31'h0, drive_active});
            rd(`ADDR_GO, 32'h0000_0001, "go held");
            if (k == 0) begin
                trig_pin <= 1'b1;
                @(posedge pclk);
                trig_pin <= 1'b0;
            end else
                wr(`ADDR_GO, 32'h0000_0000);
            wait_go();
            repeat (4) @(posedge pclk);
            if (k == 0)
                m_per = seed[7:0];
            rd(`ADDR_CAL_OUT, {8'h00, m_per, seed[15:8], seed[11:4]}, "cal out");
            rd(`ADDR_STATUS, {20'h0, m_imp, actuator_diag_pkg::ST_STANDBY, 1'b0}, "cal");
            chk("closed loop", 32'h0000_0001, {31'h0, closed_loop_active});
            chk("tracking", {31'h0, k == 0}, {31'h0, resonance_tracking});
        end
        wr(`ADDR_MODE_CTRL, 32'h0000_0008);
        repeat (2) @(posedge pclk);
        chk("erm open loop", 32'h0000_0000, {31'h0, closed_loop_active});
        wr(`ADDR_MODE_CTRL, 32'h0000_400C);
        repeat (2) @(posedge pclk);
        chk("lra open loop", 32'h0000_0000, {30'h0, closed_loop_active, resonance_tracking});
        rd(`ADDR_CAL_OUT, {8'h00, m_per, seed[15:8], seed[11:4]}, "cal kept");
        end_sim();
    end
endmodule // tb_actuator_diag_and_autocal_control

/* trigger_detect.sv */
// rising edge detector for the external trigger pin
`timescale 1ns/100ps
module trigger_detect (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic enable,
    input  wire logic trig_pin,
    output logic      trig_pulse
);
    logic prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= trig_pin;
        end
    end

    assign trig_pulse = enable & trig_pin & ~prev_r;
endmodule // trigger_detect
